// >>> xpl_pkg.sv
// shared constants for the pcs-side sixteen-lane serdes link
// assumes a 25 MHz core clock and pma-supplied link clocks
package xpl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // link geometry
    localparam int LANES     = 16;         // serial data lanes
    localparam int SER_W     = 8;          // bits per lane per parallel word
    localparam int CHANNELS  = LANES + 1;  // data lanes plus the clock lane
    localparam int CLK_CHAN  = 8;          // clock_carrier_lane position
    localparam int WORD_W    = LANES * SER_W;

    // forwarded clock pattern, one edge per serial bit
    localparam logic [SER_W-1:0] CLK_PATTERN = 8'haa;
    localparam logic [2:0]       LAST_BIT    = 3'h7;
    localparam logic [1:0]       BUF_FULL    = 2'h2;
    localparam logic [1:0]       SYNC_RST    = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // link rates in MHz (Mbps per lane), and the core clock
    localparam real RATE_WAN_MHZ   = 622.08;
    localparam real RATE_LAN_MHZ   = 644.53125;
    localparam real CORE_PERIOD_NS = 40.0;

    // serializer channel to data lane, skipping the clock lane
    function automatic int chan_lane(input int c);
        return (c < CLK_CHAN) ? c : c - 1;
    endfunction

    // lane l of a parallel word occupies bits l*SER_W upward
    function automatic logic [SER_W-1:0] lane_bits(input logic [WORD_W-1:0] w,
                                                   input int l);
        return w[l*SER_W +: SER_W];
    endfunction

endpackage

// >>> xpl_serdes.sv
// pcs-side serdes for a sixteen-lane lvds link toward a pma
// assumes the pma drives tx_source_clock and rx_recovered_clock, each
// running continuously once the link is up; i_rst is asynchronous
//
// Operation
// - Parallel core words are serialized onto sixteen separate data lanes.
// - The transmit serializer runs on the source clock that the pma supplies.
// - The forwarded clock comes from the same clock as the data, at half its bit rate.
// - The forwarded clock rides on serializer channel eight, mid-bus.
// - Sixteen receive lanes are deserialized on the pma recovered clock.
// - Receive data is sampled on the recovered clock shifted by half a period while phase tracking is off.
// - The receiver realigns word boundaries by slipping received bits.
// - Each direction has its own clock source, two in all.
// - Phase tracking is off by default and may be switched on instead.
// - Lanes and clocks run at 622.08 or 644.53125 MHz per lane.
`timescale 1ns/1ps

module xpl_serdes
    import xpl_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    input  wire logic              i_tx_valid,
    output logic                   o_tx_ready,
    input  wire logic [WORD_W-1:0] i_tx_data,
    output logic                   o_rx_valid,
    input  wire logic              i_rx_ready,
    output logic [WORD_W-1:0]      o_rx_data,
    input  wire logic              i_rx_slip,
    input  wire logic              i_dynamic_phase_tracking_en,
    output logic                   o_rx_sync_err,
    output logic                   o_rx_overrun,
    input  wire logic              i_tx_source_clock,
    output logic [CHANNELS-1:0]    o_tx_serial,
    output logic                   o_tx_forwarded_clock,
    input  wire logic              i_rx_recovered_clock,
    input  wire logic [LANES-1:0]  i_rx_serial,
    input  wire logic              i_sync_err
);

    ////////////////////////////////////////////////////////////////////////
    // state of each clock domain
    typedef struct packed {
        logic [1:0][WORD_W-1:0] tx_buf;
        logic [1:0]             tx_cnt;
        logic [WORD_W-1:0]      tx_xfer;
        logic                   tx_req;
        logic [1:0]             tx_ack_s;
        logic [1:0][WORD_W-1:0] rx_buf;
        logic [1:0]             rx_cnt;
        logic                   rx_ack;
        logic [1:0]             rx_req_s;
        logic                   slip_tgl;
        logic [1:0]             serr_s;
        logic [1:0]             ovr_s;
    } xpl_core_t;

    typedef struct packed {
        logic [1:0]                      rst_s;
        logic [1:0]                      req_s;
        logic                            ack;
        logic [2:0]                      bitcnt;
        logic [CHANNELS-1:0][SER_W-1:0]  shift;
    } xpl_tx_t;

    typedef struct packed {
        logic [1:0]                   rst_s;
        logic [LANES-1:0]             cap;
        logic [2:0]                   bitcnt;
        logic [LANES-1:0][SER_W-1:0]  shift;
        logic [WORD_W-1:0]            hold;
        logic                         req;
        logic [1:0]                   ack_s;
        logic [2:0]                   slip_s;
        logic [1:0]                   dpt_s;
        logic                         overrun;
    } xpl_rx_t;

    xpl_core_t        cq;
    xpl_core_t        cd;
    xpl_tx_t          tq;
    xpl_tx_t          td;
    xpl_rx_t          rq;
    xpl_rx_t          rd;
    logic [LANES-1:0] pos_cap_q;

    logic             tx_pop;
    logic             tx_push;
    logic             rx_pop;
    logic             rx_push;
    logic             slip_evt;
    logic [LANES-1:0] rx_bits;
    logic [WORD_W-1:0] tx_word;
    logic [WORD_W-1:0] rx_word;

    ////////////////////////////////////////////////////////////////////////
    // core domain: two-entry buffers and handshake ends
    always_comb begin
        cd = cq;
        cd.tx_ack_s = {cq.tx_ack_s[0], tq.ack};
        cd.rx_req_s = {cq.rx_req_s[0], rq.req};
        cd.serr_s   = {cq.serr_s[0], i_sync_err};
        cd.ovr_s    = {cq.ovr_s[0], rq.overrun};
        // one toggle per slip request
        // a toggle survives the crossing into the slower rx clock where a pulse could not
        cd.slip_tgl = cq.slip_tgl ^ i_rx_slip;

        // hand the head word over once the link took the last one
        tx_pop  = (cq.tx_cnt != 2'h0) && (cq.tx_req == cq.tx_ack_s[1]);
        tx_push = i_tx_valid && (cq.tx_cnt != BUF_FULL);
        if (tx_pop) begin
            cd.tx_xfer   = cq.tx_buf[0];
            cd.tx_req    = ~cq.tx_req;
            cd.tx_buf[0] = cq.tx_buf[1];
        end
        if (tx_push) begin
            cd.tx_buf[tx_pop ? 1'b0 : cq.tx_cnt[0]] = i_tx_data;
        end
        cd.tx_cnt = 2'(cq.tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop});

        // take a finished receive word; a full buffer waits instead
        rx_pop  = (cq.rx_cnt != 2'h0) && i_rx_ready;
        rx_push = (cq.rx_req_s[1] != cq.rx_ack) && (cq.rx_cnt != BUF_FULL);
        if (rx_pop) begin
            cd.rx_buf[0] = cq.rx_buf[1];
        end
        if (rx_push) begin
            cd.rx_buf[rx_pop ? 1'b0 : cq.rx_cnt[0]] = rq.hold;
            cd.rx_ack = ~cq.rx_ack;
        end
        cd.rx_cnt = 2'(cq.rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop});
    end

    // one register for the whole core state
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    // handshake outputs straight from state; data from the buffer flops
    assign o_tx_ready    = (cq.tx_cnt != BUF_FULL);
    assign o_rx_valid    = (cq.rx_cnt != 2'h0);
    assign o_rx_data     = cq.rx_buf[0];
    assign o_rx_sync_err = cq.serr_s[1];
    assign o_rx_overrun  = cq.ovr_s[1];

    ////////////////////////////////////////////////////////////////////////
    // transmit domain on the pma source clock
    always_comb begin
        td = tq;
        td.rst_s = {tq.rst_s[0], 1'b0};
        td.req_s = {tq.req_s[0], cq.tx_req};
        // idle lanes send zeros when no word is waiting
        // the word crosses as a bus; safe because req toggles with it and is seen only after two sync flops
        tx_word = (tq.req_s[1] != tq.ack) ? cq.tx_xfer : '0;
        // lane bit rate equals the source clock rate
        // one serial bit per rising source clock edge
        td.bitcnt = 3'(tq.bitcnt + 3'h1);
        for (int c = 0; c < CHANNELS; c++) begin
            td.shift[c] = {tq.shift[c][SER_W-2:0], 1'b0};
        end
        if (tq.bitcnt == 3'h0) begin
            td.ack = tq.req_s[1];
            for (int c = 0; c < CHANNELS; c++) begin
                // channel eight carries the clock pattern
                td.shift[c] = (c == CLK_CHAN) ? CLK_PATTERN
                                              : lane_bits(tx_word, chan_lane(c));
            end
        end
        if (tq.rst_s[1]) begin
            td       = '0;
            td.rst_s = {tq.rst_s[0], 1'b0};
        end
    end

    // the source clock alone paces this direction
    always_ff @(posedge i_tx_source_clock or posedge i_rst) begin
        if (i_rst) begin
            tq       <= '0;
            tq.rst_s <= SYNC_RST;
        end else begin
            tq <= td;
        end
    end

    // clock lane leaves through the same serializer as the data
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            o_tx_serial[c] = tq.shift[c][SER_W-1];
        end
    end
    assign o_tx_forwarded_clock = o_tx_serial[CLK_CHAN];

    ////////////////////////////////////////////////////////////////////////
    // receive domain on the inverted recovered clock
    // 0 degree copy, used only while phase tracking is on
    // limitation: tracking only picks the other edge, it does not follow drift
    always_ff @(posedge i_rx_recovered_clock or posedge i_rst) begin
        if (i_rst) begin
            pos_cap_q <= '0;
        end else begin
            pos_cap_q <= i_rx_serial;
        end
    end

    always_comb begin
        rd = rq;
        rd.rst_s  = {rq.rst_s[0], 1'b0};
        rd.ack_s  = {rq.ack_s[0], cq.rx_ack};
        rd.slip_s = {rq.slip_s[1:0], cq.slip_tgl};
        rd.dpt_s  = {rq.dpt_s[0], i_dynamic_phase_tracking_en};
        rd.cap    = i_rx_serial;
        slip_evt  = rq.slip_s[2] ^ rq.slip_s[1];
        rx_bits   = rq.dpt_s[1] ? pos_cap_q : rq.cap;
        rx_word   = '0;
        // a slip drops one bit so the boundary moves by one
        if (!slip_evt) begin
            rd.bitcnt = 3'(rq.bitcnt + 3'h1);
            for (int l = 0; l < LANES; l++) begin
                rd.shift[l] = {rq.shift[l][SER_W-2:0], rx_bits[l]};
                rx_word[l*SER_W +: SER_W] = rd.shift[l];
            end
            // a word is dropped, not queued, while the core still owes an ack
            // a full word goes across only if the last was taken
            if (rq.bitcnt == LAST_BIT) begin
                if (rq.req == rq.ack_s[1]) begin
                    rd.hold = rx_word;
                    rd.req  = ~rq.req;
                end else begin
                    rd.overrun = 1'b1;
                end
            end
        end
        if (rq.rst_s[1]) begin
            rd       = '0;
            rd.rst_s = {rq.rst_s[0], 1'b0};
        end
    end

    // negedge sampling is the 180 degree shift
    always_ff @(negedge i_rx_recovered_clock or posedge i_rst) begin
        if (i_rst) begin
            rq       <= '0;
            rq.rst_s <= SYNC_RST;
        end else begin
            rq <= rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    tx_accept_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_tx_valid && o_tx_ready && cq.tx_cnt == 2'h0) |=> (cq.tx_cnt != 2'h0
        || cq.tx_req != $past(cq.tx_req)))
        else $error("accepted word vanished");

    tx_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (cq.tx_req != cq.tx_ack_s[1]) |=> $stable(cq.tx_xfer) || $past(tx_pop))
        else $error("transmit word changed during handover");

    tx_bit_pace_a: assert property (@(posedge i_tx_source_clock)
        disable iff (i_rst || tq.rst_s[1])
        (tq.bitcnt == LAST_BIT) |=> (tq.bitcnt == 3'h0) ##1 (tq.bitcnt == 3'h1))
        else $error("serial bit counter out of step");

    clock_lane_a: assert property (@(posedge i_tx_source_clock)
        disable iff (i_rst || tq.rst_s[1] || tq.rst_s[0])
        o_tx_forwarded_clock == tq.bitcnt[0])
        else $error("clock lane pattern wrong");

    rx_word_a: assert property (@(negedge i_rx_recovered_clock)
        disable iff (i_rst || rq.rst_s[1])
        (rq.bitcnt == LAST_BIT && !slip_evt) |=> (rq.req != $past(rq.req)
        || rq.overrun))
        else $error("finished word neither sent nor flagged");

    rx_stall_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_rx_valid && !i_rx_ready) |=> o_rx_valid && $stable(o_rx_data))
        else $error("stalled receive word lost");

    slip_hold_a: assert property (@(negedge i_rx_recovered_clock)
        disable iff (i_rst || rq.rst_s[1])
        slip_evt |=> rq.bitcnt == $past(rq.bitcnt))
        else $error("slip did not hold the boundary");

    boundary_keep_a: assert property (@(negedge i_rx_recovered_clock)
        disable iff (i_rst || rq.rst_s[1])
        !slip_evt |=> rq.bitcnt == 3'($past(rq.bitcnt) + 3'h1))
        else $error("boundary moved without a slip");

    ////////////////////////////////////////////////////////////////////////
    // buffer bounds, sticky flags and per-domain datapath checks
    tx_count_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cq.tx_cnt != 2'h3)
        else $error("transmit buffer count past two");

    rx_count_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cq.rx_cnt != 2'h3)
        else $error("receive buffer count past two");

    overrun_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_rx_overrun |=> o_rx_overrun)
        else $error("overrun flag cleared itself");

    overrun_keep_a: assert property (@(negedge i_rx_recovered_clock)
        disable iff (i_rst || rq.rst_s[1])
        rq.overrun |=> rq.overrun)
        else $error("link overrun flag cleared itself");

    clock_load_a: assert property (@(posedge i_tx_source_clock)
        disable iff (i_rst || tq.rst_s[1])
        (tq.bitcnt == 3'h0) |=> (tq.shift[CLK_CHAN] == CLK_PATTERN))
        else $error("clock lane not loaded with the data");

    tx_load_a: assert property (@(posedge i_tx_source_clock)
        disable iff (i_rst || tq.rst_s[1])
        (tq.bitcnt == 3'h0) |=> (tq.ack == $past(tq.req_s[1])))
        else $error("pending word not taken at word start");

    tx_idle_a: assert property (@(posedge i_tx_source_clock)
        disable iff (i_rst || tq.rst_s[1])
        (tq.bitcnt == 3'h0 && tq.req_s[1] == tq.ack) |=> (tq.shift[0] == '0))
        else $error("idle lane not sending zeros");

    half_sample_a: assert property (@(negedge i_rx_recovered_clock)
        disable iff (i_rst || rq.rst_s[1])
        (!rq.dpt_s[1] && !slip_evt) |=> (rq.shift[0][0] == $past(rq.cap[0])))
        else $error("baseline did not use the shifted sample");

    track_sample_a: assert property (@(negedge i_rx_recovered_clock)
        disable iff (i_rst || rq.rst_s[1])
        (rq.dpt_s[1] && !slip_evt) |=> (rq.shift[0][0] == $past(pos_cap_q[0])))
        else $error("tracking did not use the other sample");

endmodule

// >>> xpl_pma_model.sv
// pma-side model of the sixteen-lane link: both link clocks, rx lanes, tx capture
// assumes the serdes sends lane bytes msb first and idles with zero words
`timescale 1ns/1ps

module xpl_pma_model
    import xpl_pkg::*;
(
    output logic                     o_tx_source_clock,
    output logic                     o_rx_recovered_clock,
    output logic [LANES-1:0]         o_rx_serial,
    input  wire logic [CHANNELS-1:0] i_tx_serial,
    input  wire logic                i_tx_forwarded_clock,
    input  wire logic [WORD_W-1:0]   i_rx_word
);
    logic [WORD_W-1:0] got_q[$];  // captured tx words, oldest first
    logic [7:0]        ch [CHANNELS];
    logic [7:0]        clk_byte;  // clock lane of the last captured word
    logic [WORD_W-1:0] w;
    int                cnt;
    int                bit_i;
    int                fwd_bad;
    logic              fwd_prev;  // forwarded clock at the previous bit

    ////////////////////////////////////////////////////////////////////////
    // two free-running link clocks, unrelated in phase
    initial begin
        o_tx_source_clock = 1'b0;
        o_rx_recovered_clock = 1'b0;
        o_rx_serial = '0;
        cnt = 0;
        bit_i = 7;
        fwd_bad = 0;
        fwd_prev = 1'b0;
        #7;
        fork
            forever #40 o_tx_source_clock = ~o_tx_source_clock;
            begin
                #16;
                forever #40 o_rx_recovered_clock = ~o_rx_recovered_clock;
            end
        join
    end

    // repeat the word msb first; change mid-high so either edge samples cleanly
    always @(posedge o_rx_recovered_clock) begin
        #20;
        for (int l = 0; l < LANES; l++)
            o_rx_serial[l] = i_rx_word[l*8 + bit_i];
        bit_i = (bit_i == 0) ? 7 : bit_i - 1;
    end

    // frame starts on a set msb of lane 0; data settles after the rising edge
    always @(negedge o_tx_source_clock) begin
        if (cnt > 0 || i_tx_serial[0] === 1'b1) begin
            // inside a frame the forwarded clock flips on every bit
            if (i_tx_forwarded_clock === fwd_prev)
                fwd_bad++;
            for (int c = 0; c < CHANNELS; c++)
                ch[c] = {ch[c][6:0], i_tx_serial[c]};
            cnt++;
            if (cnt == 8) begin
                for (int l = 0; l < LANES; l++)
                    w[l*8 +: 8] = ch[(l < 8) ? l : l + 1];
                clk_byte = ch[8];
                got_q.push_back(w);
                cnt = 0;
            end
        end
        fwd_prev = i_tx_forwarded_clock;
    end
endmodule

// >>> testbench.sv
// self-checking bench for the sixteen-lane serdes
// assumes the pma model on the link side; the core side is driven here
`timescale 1ns/1ps

module testbench;
    import xpl_pkg::*;
    logic                core_clk, rst, tx_valid, tx_ready, rx_valid, rx_ready;
    logic                rx_slip, track_en, sync_err, rx_sync_err, rx_overrun;
    logic                tx_src, rx_rec, fwd_clk, rx_drain;
    logic [WORD_W-1:0]   tx_data, rx_data, rx_word, pat, w, e;
    logic [CHANNELS-1:0] tx_serial;
    logic [LANES-1:0]    rx_serial;
    logic [WORD_W-1:0]   rx_q[$];
    int                  n_fail, compares, stalls;

    xpl_serdes i_xpl_serdes (.i_core_clk(core_clk), .i_rst(rst), .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready), .i_tx_data(tx_data), .o_rx_valid(rx_valid),
        .i_rx_ready(rx_ready), .o_rx_data(rx_data), .i_rx_slip(rx_slip),
        .i_dynamic_phase_tracking_en(track_en), .o_rx_sync_err(rx_sync_err),
        .o_rx_overrun(rx_overrun), .i_tx_source_clock(tx_src), .o_tx_serial(tx_serial),
        .o_tx_forwarded_clock(fwd_clk), .i_rx_recovered_clock(rx_rec),
        .i_rx_serial(rx_serial), .i_sync_err(sync_err));
    xpl_pma_model i_xpl_pma_model (.o_tx_source_clock(tx_src),
        .o_rx_recovered_clock(rx_rec), .o_rx_serial(rx_serial), .i_tx_serial(tx_serial),
        .i_tx_forwarded_clock(fwd_clk), .i_rx_word(rx_word));

    ////////////////////////////////////////////////////////////////////////
    // core clock and rx drain; reads happen before the edge's updates land
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge core_clk) rx_ready <= rx_drain;
    always @(posedge core_clk)
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);

    task automatic give_verdict();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_word(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] x);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk_bit(input logic g, input logic x);
        chk_word({127'h0, g}, {127'h0, x});
    endtask
    // lane bytes with the msb set, so the model can find each frame
    function automatic logic [WORD_W-1:0] mk(input int k);
        for (int l = 0; l < LANES; l++)
            mk[l*8 +: 8] = {1'b1, k[2:0], l[3:0]};
    endfunction
    task automatic send_word(input logic [WORD_W-1:0] d);
        int n;
        @(negedge core_clk);
        tx_valid = 1'b1;
        tx_data = d;
        for (n = 0; n < 200; n++) begin
            @(posedge core_clk);
            if (tx_ready === 1'b1) break;
            stalls++;
        end
        if (n == 200) begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic pop_word(input bit from_tx, output logic [WORD_W-1:0] d);
        int n;
        for (n = 0; n < 400; n++) begin
            if (from_tx ? i_xpl_pma_model.got_q.size() > 0 : rx_q.size() > 0) break;
            @(negedge core_clk);
        end
        if (n == 400) begin
            n_fail++;
            give_verdict();
        end
        d = from_tx ? i_xpl_pma_model.got_q.pop_front() : rx_q.pop_front();
    endtask
    // one slip pulse, then let words with the old boundary drain away
    task automatic slip_once();
        @(negedge core_clk);
        rx_slip = 1'b1;
        @(negedge core_clk);
        rx_slip = 1'b0;
        repeat (60) @(negedge core_clk);
        rx_q.delete();
    endtask
    task automatic align();
        for (int k = 0; k < 9; k++) begin
            pop_word(0, w);
            if (w === pat) break;
            slip_once();
        end
        chk_word(w, pat);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // four back-to-back tx words, at least one refused, then check each lane on the wire
    task automatic t_tx();
        stalls = 0;
        for (int k = 1; k < 5; k++)
            send_word(mk(k));
        @(negedge core_clk);
        tx_valid = 1'b0;
        chk_bit(stalls > 0, 1'b1);
        for (int k = 1; k < 5; k++) begin
            pop_word(1, w);
            chk_word(w, mk(k));
        end
        chk_word({120'h0, i_xpl_pma_model.clk_byte}, {120'h0, 8'haa});
        chk_bit(i_xpl_pma_model.fwd_bad == 0, 1'b1);
        $display("test tx done");
    endtask
    // rx alignment search, boundary hold, one slip, then the other sample edge
    task automatic t_rx();
        pat = mk(0);
        rx_word = pat;
        // drop the idle words that piled up while the tx test ran
        repeat (60) @(negedge core_clk);
        rx_q.delete();
        align();
        for (int k = 0; k < 2; k++) begin
            pop_word(0, w);
            chk_word(w, pat);
        end
        slip_once();
        for (int l = 0; l < LANES; l++)
            e[l*8 +: 8] = {pat[l*8 +: 7], pat[l*8 + 7]};
        pop_word(0, w);
        chk_word(w, e);
        track_en = 1'b1;
        slip_once();
        align();
        $display("test rx done");
    endtask
    // sync error path, then a receiver stall that must flag lost words
    task automatic t_flags();
        sync_err = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_bit(rx_sync_err, 1'b1);
        sync_err = 1'b0;
        repeat (4) @(negedge core_clk);
        chk_bit(rx_sync_err, 1'b0);
        chk_bit(rx_overrun, 1'b0);
        rx_drain = 1'b0;
        repeat (120) @(negedge core_clk);
        chk_bit(rx_overrun, 1'b1);
        rx_q.delete();
        rx_drain = 1'b1;
        pop_word(0, w);
        chk_word(w, pat);
        $display("test flags done");
    endtask

    initial begin
        {rst, tx_valid, rx_slip, track_en, sync_err, rx_drain} = 6'h21;
        tx_data = '0;
        rx_word = '0;
        n_fail = 0;
        compares = 0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_tx();
        t_rx();
        t_flags();
        give_verdict();
    end
endmodule
